// File: hw/arcc_regs.v
// result, compare, configuration and pin-control registers of the converter
// Contract
// - high result holds top 4 bits (12-bit) or 2 bits (10-bit); unused bits zero
// - results load at each completion unless locked, or compare is enabled and fails
// - on a compare event the stored value is result minus compare value
// - in 12/10-bit mode reading high result locks results until low is read
// - conversions finishing while locked are discarded
// - in 8-bit mode there is no read interlock
// - low result holds lower eight bits, or the whole 8-bit result
// - high compare register compared to top 4/2 bits; ignored in 8-bit mode
// - low compare bits 7:0 compared with lower eight result bits in all modes
// - configuration bit 7 selects high speed (0) or low power (1)
// - configuration bits 6:5 divide input clock by 1, 2, 4 or 8
// - configuration bit 4 selects short (0) or long (1) sample time
// - configuration bits 3:2 select 8, 12 or 10-bit resolution; 11 reserved
// - configuration bits 1:0 select bus, bus/2, alternate or async clock
// - pin-control bit n disables port control of channel n pin
// - set pin bit forces output hi-z, input off reading zero, pullup off
// - complete flag sets on store, clears on status write or low result read
// - compare true when result below value (select 0) or at/above it (select 1)
`include "arcc_consts.vh"
module arcc_regs #(
   parameter RES_W = 12,
   parameter PINS = 8
) (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [11:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire hready,
   input wire [31:0] hwdata,
   output reg [31:0] hrdata,
   output wire hreadyout,
   output wire hresp,
   input wire conv_done,
   input wire [RES_W-1:0] conv_result,
   input wire alternate_clock,
   input wire internal_async_clock,
   output wire converter_clock_en,
   output wire low_power_select,
   output wire long_sample_select,
   output wire [1:0] mode_select,
   output wire [1:0] input_clock_select,
   output wire [1:0] clock_divide_select,
   output wire conversion_complete_flag,
   input wire [PINS-1:0] port_out,
   input wire [PINS-1:0] port_oe,
   input wire [PINS-1:0] port_pullup,
   input wire [PINS-1:0] pin_in,
   output wire [PINS-1:0] pin_out,
   output wire [PINS-1:0] pin_oe,
   output wire [PINS-1:0] pin_pullup,
   output wire [PINS-1:0] port_in
);
   reg [7:0] cfg_q;
   reg [7:0] cmp_hi_q;
   reg [7:0] cmp_lo_q;
   reg [7:0] pin_ctl_q;
   reg [1:0] cmp_ctl_q;
   reg [RES_W-1:0] result_q;
   reg conversion_complete_flag_q;
   reg lock_q;
   reg wr_pend_q;
   reg [11:0] wr_addr_q;
   reg [2:0] div_cnt_q;
   reg bus2_q;
   reg alt_q;
   reg async_q;
   reg alt_prev_q;
   reg async_prev_q;
   reg [RES_W-1:0] res_masked;
   reg [RES_W-1:0] cmp_masked;
   reg [RES_W-1:0] diff_masked;
   reg cmp_true;
   reg src_tick;
   reg [2:0] div_mask;
   wire addr_phase;
   wire rd_req;
   wire wr_req;
   wire rd_low;
   wire rd_high;
   wire [1:0] mode;
   wire store;
   wire [15:0] cmp_full;
   wire [RES_W-1:0] cmp_value;
   wire [RES_W-1:0] diff_value;

   assign mode = cfg_q[`ARCC_CFG_MODE_HI:`ARCC_CFG_MODE_LO];
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign addr_phase = hsel && hready && (htrans == `ARCC_HTRANS_NONSEQ);
   assign rd_req = addr_phase && !hwrite;
   assign wr_req = addr_phase && hwrite;
   assign rd_low = rd_req && (haddr == `ARCC_OFF_RESULT_LOW);
   assign rd_high = rd_req && (haddr == `ARCC_OFF_RESULT_HIGH);

   // compare value assembled to the result width
   assign cmp_full = {cmp_hi_q, cmp_lo_q};
   assign cmp_value = cmp_full[RES_W-1:0];

   // conversion result and compare value masked to the active resolution
   always @* begin
      res_masked = conv_result;
      cmp_masked = cmp_value;
      if (mode == `ARCC_MODE_8) begin
         res_masked[RES_W-1:8] = {(RES_W-8){1'b0}};
         cmp_masked[RES_W-1:8] = {(RES_W-8){1'b0}};
      end else if (mode == `ARCC_MODE_10) begin
         res_masked[RES_W-1:10] = {(RES_W-10){1'b0}};
         cmp_masked[RES_W-1:10] = {(RES_W-10){1'b0}};
      end
      // the low compare bits always take part
      if (cmp_ctl_q[`ARCC_CTL_CMP_GT]) begin
         cmp_true = (res_masked >= cmp_masked);
      end else begin
         cmp_true = (res_masked < cmp_masked);
      end
   end

   // result plus two's complement of compare value
   assign diff_value = res_masked + (~cmp_masked + {{(RES_W-1){1'b0}}, 1'b1});

   always @* begin
      diff_masked = diff_value;
      if (mode == `ARCC_MODE_8) begin
         diff_masked[RES_W-1:8] = {(RES_W-8){1'b0}};
      end else if (mode == `ARCC_MODE_10) begin
         diff_masked[RES_W-1:10] = {(RES_W-10){1'b0}};
      end
   end

   // a locked result drops the conversion entirely
   assign store = conv_done && !lock_q && (!cmp_ctl_q[`ARCC_CTL_CMP_EN] || cmp_true);

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         result_q <= {RES_W{1'b0}};
         lock_q <= 1'b0;
         conversion_complete_flag_q <= 1'b0;
      end else begin
         if (store) begin
            if (cmp_ctl_q[`ARCC_CTL_CMP_EN]) begin
               result_q <= diff_masked;
            end else begin
               result_q <= res_masked;
            end
         end
         // outside 8-bit mode a read of the high byte holds results until the low byte is read
         if (rd_low || mode == `ARCC_MODE_8) begin
            lock_q <= 1'b0;
         end else if (rd_high) begin
            lock_q <= 1'b1;
         end
         // set wins over a clear in the same cycle
         if (store) begin
            conversion_complete_flag_q <= 1'b1;
         end else if (rd_low || (wr_pend_q && wr_addr_q == `ARCC_OFF_STATUS)) begin
            conversion_complete_flag_q <= 1'b0;
         end
      end
   end

   // write data phase follows the captured address phase
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 12'h000;
         cfg_q <= `ARCC_RESET_BYTE;
         cmp_hi_q <= `ARCC_RESET_BYTE;
         cmp_lo_q <= `ARCC_RESET_BYTE;
         pin_ctl_q <= `ARCC_RESET_BYTE;
         cmp_ctl_q <= 2'h0;
      end else begin
         wr_pend_q <= wr_req;
         if (wr_req) begin
            wr_addr_q <= haddr;
         end
         if (wr_pend_q) begin
            if (wr_addr_q == `ARCC_OFF_CMP_HIGH) begin
               cmp_hi_q <= hwdata[7:0];
            end else if (wr_addr_q == `ARCC_OFF_CMP_LOW) begin
               cmp_lo_q <= hwdata[7:0];
            end else if (wr_addr_q == `ARCC_OFF_CONFIG) begin
               cfg_q <= hwdata[7:0];
            end else if (wr_addr_q == `ARCC_OFF_PIN_CTL) begin
               pin_ctl_q <= hwdata[7:0];
            end else if (wr_addr_q == `ARCC_OFF_CMP_CTL) begin
               cmp_ctl_q <= hwdata[1:0];
            end
         end
      end
   end

   // read data registered at the address phase; unmapped reads return zero
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (rd_req) begin
         if (haddr == `ARCC_OFF_RESULT_HIGH) begin
            hrdata <= {{(40-RES_W){1'b0}}, result_q[RES_W-1:8]};
         end else if (haddr == `ARCC_OFF_RESULT_LOW) begin
            hrdata <= {24'h00_0000, result_q[7:0]};
         end else if (haddr == `ARCC_OFF_CMP_HIGH) begin
            hrdata <= {24'h00_0000, cmp_hi_q};
         end else if (haddr == `ARCC_OFF_CMP_LOW) begin
            hrdata <= {24'h00_0000, cmp_lo_q};
         end else if (haddr == `ARCC_OFF_CONFIG) begin
            hrdata <= {24'h00_0000, cfg_q};
         end else if (haddr == `ARCC_OFF_PIN_CTL) begin
            hrdata <= {24'h00_0000, pin_ctl_q};
         end else if (haddr == `ARCC_OFF_CMP_CTL) begin
            hrdata <= {30'h0000_0000, cmp_ctl_q};
         end else if (haddr == `ARCC_OFF_STATUS) begin
            hrdata <= {30'h0000_0000, lock_q, conversion_complete_flag_q};
         end else begin
            hrdata <= 32'h0000_0000;
         end
      end
   end

   // clock source edges, sampled on hclk, then divided into an enable pulse
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bus2_q <= 1'b0;
         alt_q <= 1'b0;
         async_q <= 1'b0;
         alt_prev_q <= 1'b0;
         async_prev_q <= 1'b0;
      end else begin
         bus2_q <= ~bus2_q;
         alt_q <= alternate_clock;
         async_q <= internal_async_clock;
         alt_prev_q <= alt_q;
         async_prev_q <= async_q;
      end
   end

   always @* begin
      case (input_clock_select)
         `ARCC_CLK_BUS: src_tick = 1'b1;
         `ARCC_CLK_BUS2: src_tick = bus2_q;
         `ARCC_CLK_ALT: src_tick = alt_q && !alt_prev_q;
         default: src_tick = async_q && !async_prev_q;
      endcase
      case (clock_divide_select)
         2'h0: div_mask = 3'h0;
         2'h1: div_mask = 3'h1;
         2'h2: div_mask = 3'h3;
         default: div_mask = 3'h7;
      endcase
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_cnt_q <= 3'h0;
      end else if (src_tick) begin
         div_cnt_q <= div_cnt_q + 3'h1;
      end
   end

   assign converter_clock_en = src_tick && ((div_cnt_q & div_mask) == div_mask);

   assign low_power_select = cfg_q[`ARCC_CFG_LOWPWR];
   assign long_sample_select = cfg_q[`ARCC_CFG_LSMP];
   assign mode_select = mode;
   assign input_clock_select = cfg_q[`ARCC_CFG_CLK_HI:`ARCC_CFG_CLK_LO];
   assign clock_divide_select = cfg_q[`ARCC_CFG_DIV_HI:`ARCC_CFG_DIV_LO];
   assign conversion_complete_flag = conversion_complete_flag_q;

   // per-pin override of the port logic
   genvar i;
   generate
      for (i = 0; i < PINS; i = i + 1) begin : g_pin
         assign pin_out[i] = pin_ctl_q[i] ? 1'b0 : port_out[i];
         assign pin_oe[i] = pin_ctl_q[i] ? 1'b0 : port_oe[i];
         assign pin_pullup[i] = pin_ctl_q[i] ? 1'b0 : port_pullup[i];
         assign port_in[i] = pin_ctl_q[i] ? 1'b0 : pin_in[i];
      end
   endgenerate
endmodule

// File: hw/arcc_consts.vh
// register map, field positions and encodings of the converter register block
`ifndef ARCC_CONSTS_VH
`define ARCC_CONSTS_VH
`define ARCC_OFF_RESULT_HIGH 12'h000
`define ARCC_OFF_RESULT_LOW 12'h004
`define ARCC_OFF_CMP_HIGH 12'h008
`define ARCC_OFF_CMP_LOW 12'h00c
`define ARCC_OFF_CONFIG 12'h010
`define ARCC_OFF_PIN_CTL 12'h014
`define ARCC_OFF_CMP_CTL 12'h018
`define ARCC_OFF_STATUS 12'h01c
`define ARCC_CFG_LOWPWR 7
`define ARCC_CFG_DIV_HI 6
`define ARCC_CFG_DIV_LO 5
`define ARCC_CFG_LSMP 4
`define ARCC_CFG_MODE_HI 3
`define ARCC_CFG_MODE_LO 2
`define ARCC_CFG_CLK_HI 1
`define ARCC_CFG_CLK_LO 0
`define ARCC_MODE_8 2'h0
`define ARCC_MODE_12 2'h1
`define ARCC_MODE_10 2'h2
`define ARCC_CLK_BUS 2'h0
`define ARCC_CLK_BUS2 2'h1
`define ARCC_CLK_ALT 2'h2
`define ARCC_CLK_ASYNC 2'h3
`define ARCC_CTL_CMP_EN 0
`define ARCC_CTL_CMP_GT 1
`define ARCC_ST_CONVERSION_COMPLETE_FLAG 0
`define ARCC_ST_LOCK 1
`define ARCC_RESET_BYTE 8'h00
`define ARCC_HTRANS_NONSEQ 2'h2
`define ARCC_HSIZE_WORD 3'h2
`endif

// File: testbench/arcc_regs_asserts.sv
// port-level checker of the converter register block
module arcc_checker #(
   parameter PINS = 8
) (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [11:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire hready,
   input wire [31:0] hwdata,
   input wire hreadyout,
   input wire hresp,
   input wire conv_done,
   input wire conversion_complete_flag,
   input wire converter_clock_en,
   input wire low_power_select,
   input wire long_sample_select,
   input wire [1:0] mode_select,
   input wire [1:0] input_clock_select,
   input wire [1:0] clock_divide_select,
   input wire [PINS-1:0] port_out,
   input wire [PINS-1:0] port_oe,
   input wire [PINS-1:0] port_pullup,
   input wire [PINS-1:0] pin_in,
   input wire [PINS-1:0] pin_out,
   input wire [PINS-1:0] pin_oe,
   input wire [PINS-1:0] pin_pullup,
   input wire [PINS-1:0] port_in
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   wire tk = hsel && hready && htrans == 2'h2;
   bus_okay_a: assert property (hreadyout && !hresp) else $error("bus answer not okay");
   pin_mask_a: assert property (((pin_out & ~port_out) | (pin_oe & ~port_oe) | (port_in & ~pin_in)) == 0)
      else $error("pin output passes more than port drive");
   pin_force_a: assert property (((port_oe & ~pin_oe) & (pin_pullup | port_in | pin_out)) == 0)
      else $error("forced pin not fully released");
   low_read_clr_a: assert property (tk && !hwrite && haddr == 12'h004 && !conv_done |=> !conversion_complete_flag)
      else $error("flag kept after low result read");
   status_wr_clr_a: assert property (tk && hwrite && haddr == 12'h01c ##1 !conv_done |=> !conversion_complete_flag)
      else $error("flag kept after status write");
   flag_cause_a: assert property ($rose(conversion_complete_flag) |-> $past(conv_done))
      else $error("flag set without conversion");
   cfg_write_a: assert property (tk && hwrite && haddr == 12'h010 ##1 1'b1 |=>
      {low_power_select, clock_divide_select, long_sample_select, mode_select, input_clock_select} == $past(hwdata[7:0]))
      else $error("configuration fields differ from written value");
   clk_div1_a: assert property (input_clock_select == 2'h0 && clock_divide_select == 2'h0 |-> converter_clock_en)
      else $error("bus clock undivided gives no tick");
endmodule

bind arcc_regs arcc_checker #(.PINS(PINS)) chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp),
   .conv_done(conv_done), .conversion_complete_flag(conversion_complete_flag), .converter_clock_en(converter_clock_en),
   .low_power_select(low_power_select), .long_sample_select(long_sample_select), .mode_select(mode_select),
   .input_clock_select(input_clock_select), .clock_divide_select(clock_divide_select), .port_out(port_out),
   .port_oe(port_oe), .port_pullup(port_pullup), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
   .pin_pullup(pin_pullup), .port_in(port_in));

// File: testbench/tb_top.sv
// self-checking bench of the converter register block
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk, hresetn = 0, hsel = 0, hwrite = 0, conv_done = 0;
   logic [11:0] haddr = 0, conv_result = 0;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 3'h2, cnt = 0;
   logic [31:0] hwdata = 0, r;
   logic [7:0] pin_in = 8'hff, v;
   wire [31:0] hrdata;
   wire [7:0] pin_out, pin_oe, pin_pullup, port_in;
   wire hreadyout, hresp, cce, lp, ls, ccf;
   wire [1:0] ms, ics, cds;
   int errors = 0, checks = 0, i, ticks = 0, t0;
   arcc_regs dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .conv_done(conv_done), .conv_result(conv_result), .alternate_clock(cnt[1]), .internal_async_clock(cnt[2]),
      .converter_clock_en(cce), .low_power_select(lp), .long_sample_select(ls), .mode_select(ms),
      .input_clock_select(ics), .clock_divide_select(cds), .conversion_complete_flag(ccf), .port_out(8'hff),
      .port_oe(8'hff), .port_pullup(8'hff), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin_pullup(pin_pullup), .port_in(port_in));
   initial begin
      hclk = 0;
      forever #2.5 hclk = ~hclk;
   end
   always @(posedge hclk) cnt <= cnt + 3'h1;
   // converter clock pulses, counted on the edge that samples them
   always @(posedge hclk) ticks <= ticks + cce;
   task print_verdict;
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task check(input [31:0] got, input [31:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task xfer(input [11:0] a, input w, input [7:0] d);
      hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0; hwdata <= {24'h0, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task rd(input [11:0] a, input [7:0] e);
      xfer(a, 1'b0, 8'h00);
      check(r, {24'h0, e});
   endtask
   // pulses of the converter clock enable over 16 cycles under one configuration
   task tick_count(input [7:0] c, input [31:0] e);
      xfer(12'h010, 1'b1, c);
      @(posedge hclk);
      t0 = ticks;
      repeat (16) @(posedge hclk);
      check(ticks - t0, e);
   endtask
   task conv(input [11:0] x);
      conv_done <= 1'b1; conv_result <= x;
      @(posedge hclk);
      conv_done <= 1'b0;
      @(posedge hclk);
   endtask
   initial begin
      #20000;
      errors++;
      print_verdict;
   end
   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      xfer(12'h024, 1'b1, 8'hff);
      for (i = 0; i <= 36; i += 4) rd(i[11:0], 8'h00);
      for (i = 0; i < 16; i++) begin
         v = {i[0], i[3:2], i[1], 2'h0, i[1:0]};
         xfer(12'h010, 1'b1, v);
         @(posedge hclk);
         check({24'h0, lp, cds, ls, ms, ics}, {24'h0, v});
      end
      xfer(12'h010, 1'b1, 8'h04);
      @(posedge hclk);
      check({30'h0, ms}, 32'h1);
      conv(12'habc);
      rd(12'h000, 8'h0a);
      rd(12'h01c, 8'h03);
      conv(12'h123);
      rd(12'h004, 8'hbc);
      rd(12'h01c, 8'h00);
      conv(12'h456);
      rd(12'h000, 8'h04);
      rd(12'h004, 8'h56);
      xfer(12'h010, 1'b1, 8'h08);
      conv(12'hfff);
      rd(12'h000, 8'h03);
      rd(12'h004, 8'hff);
      xfer(12'h010, 1'b1, 8'h00);
      conv(12'hfab);
      rd(12'h000, 8'h00);
      conv(12'h0cd);
      rd(12'h004, 8'hcd);
      xfer(12'h010, 1'b1, 8'h04);
      conv(12'h777);
      xfer(12'h01c, 1'b1, 8'h00);
      rd(12'h01c, 8'h00);
      xfer(12'h008, 1'b1, 8'h02);
      xfer(12'h00c, 1'b1, 8'h00);
      xfer(12'h018, 1'b1, 8'h01);
      conv(12'h300);
      rd(12'h01c, 8'h00);
      conv(12'h150);
      rd(12'h000, 8'h0f);
      rd(12'h004, 8'h50);
      xfer(12'h018, 1'b1, 8'h03);
      conv(12'h2a7);
      rd(12'h000, 8'h00);
      rd(12'h004, 8'ha7);
      conv(12'h150);
      rd(12'h01c, 8'h00);
      xfer(12'h010, 1'b1, 8'h08);
      xfer(12'h008, 1'b1, 8'h00);
      xfer(12'h00c, 1'b1, 8'hff);
      conv(12'h3ff);
      rd(12'h000, 8'h03);
      xfer(12'h010, 1'b1, 8'h00);
      xfer(12'h008, 1'b1, 8'h03);
      xfer(12'h00c, 1'b1, 8'h10);
      conv(12'h020);
      rd(12'h004, 8'h10);
      xfer(12'h014, 1'b1, 8'ha5);
      rd(12'h014, 8'ha5);
      check({pin_out, pin_oe, pin_pullup, port_in}, 32'h5a5a5a5a);
      tick_count(8'h00, 32'd16);
      tick_count(8'h60, 32'd2);
      tick_count(8'h21, 32'd4);
      tick_count(8'h02, 32'd4);
      tick_count(8'h03, 32'd2);
      print_verdict;
   end
endmodule
